/* rtl/pin_wake_detect.sv */
/*
  GPIO wake detector: synchronises the pins, applies polarity and enables,
  and reports one-cycle wake events. Assumes pins are asynchronous to the clock.
*/
module pin_wake_detect (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic [pm_pkg::GPIO_W-1:0] i_gpio_pins,
  input wire logic [pm_pkg::GPIO_W-1:0] i_gpio_wake_en,
  input wire logic [pm_pkg::GPIO_W-1:0] i_gpio_pol,
  input wire logic i_phy_link_up,
  input wire logic i_link_up_wake_enable,
  wake_if.det wk
);
  import pm_pkg::*;

  logic [GPIO_W-1:0] meta_r;
  logic [GPIO_W-1:0] sync_r;
  logic [GPIO_W-1:0] active;
  logic [GPIO_W-1:0] armed;
  logic [GPIO_W-1:0] prev_r;

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= i_gpio_pins;
      sync_r <= meta_r;
    end
  end

  // Polarity and enables; the link-up source replaces the pin on GPIO7
  always_comb begin
    active = ~(sync_r ^ i_gpio_pol);
    armed = i_gpio_wake_en;
    if (i_link_up_wake_enable) begin
      active[LINK_GPIO_IDX] = i_phy_link_up; // Pin level ignored in this mode
      armed[LINK_GPIO_IDX] = wk.link_allowed;
    end
  end

  // Previous level for edge detection, so a held level wakes only once
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      prev_r <= '0;
    end else begin
      prev_r <= active;
    end
  end

  assign wk.gpio_evt = active & ~prev_r & armed & {GPIO_W{wk.in_sleep}};
endmodule : pin_wake_detect

/* rtl/pm_pkg.sv */
/*
  Shared constants and types for the suspend/wake power-state controller.
  Assumes one core clock domain; every user of these names imports pm_pkg.
*/
package pm_pkg;
  // GPIO wake pins and the pin that doubles as link-up wake
  localparam int GPIO_W = 11;
  localparam int LINK_GPIO_IDX = 7;

  // Suspend-select field encodings
  localparam int SEL_W = 2;
  localparam logic [SEL_W-1:0] SEL_S0 = 2'h0;
  localparam logic [SEL_W-1:0] SEL_S1 = 2'h1;
  localparam logic [SEL_W-1:0] SEL_S2 = 2'h2;
  localparam logic [SEL_W-1:0] SEL_S3 = 2'h3;
  localparam logic [SEL_W-1:0] SEL_RESET = SEL_S2;

  // Wake status field layout
  localparam int WS_W = 2;
  localparam int WS_LAN_BIT = 0;
  localparam int WS_ENERGY_BIT = 1;
  localparam logic [WS_W-1:0] WS_RESET = 2'h0;
  localparam logic [GPIO_W-1:0] PIN_WS_RESET = 11'h000;

  // Power states
  typedef enum logic [2:0] {
    ST_NORM_UNCONF,
    ST_NORM_CONF,
    ST_SLEEP_S0,
    ST_SLEEP_S1,
    ST_SLEEP_S2,
    ST_SLEEP_S3
  } pm_state_type;
endpackage : pm_pkg

/* rtl/usb_suspend_wake_state_control.sv */
/*
  Power-state controller: normal (unconfigured/configured) and four suspend
  states, with wake gating, wake status and pin wake status.
  Assumes USB events, MAC and PHY events are single-cycle pulses on the core
  clock; the external reset pin and GPIO pins are asynchronous.
*/
// Notes on behaviour
// - System reset places the device in unconfigured normal state.
// - Ready flag high in normal state; after USB reset waits for EEPROM load.
// - Returning from suspend keeps USB context; no reinit pulse.
// - Host selects suspend state then suspends; entry only from normal.
// - Host resume or permitted enabled wake returns device to normal.
// - Suspend from unconfigured enters sleep_s2 only; wakes back unconfigured.
// - Deconfiguration reverts suspend-select to sleep_s2 encoding.
// - USB reset or external pin reset reinitialises and enters unconfigured normal.
// - Suspend-select encodes s0..s3 as 00b..11b; sleep_s2 default.
// - Wake sources per state: resume, GPIO always; LAN s0; energy s1; frame s3; link s0/s3.
// - All clocks stay enabled in sleep_s3; frames may be lost.
// - Any frame wake source enabled in sleep_s3 drops all frames.
// - LAN wake status bit also flags good-frame wake from sleep_s3.
// - Each GPIO wake sets its own pin wake status bit.
// - A still pending wake event wakes the device again at once.
// - Link-up wake enable tells link-up from pin on GPIO7.
// - Good frame: passes MAC filter with no frame wake source enabled.
// - Deconfiguration while configured returns to unconfigured normal.
// - Completed configuration moves unconfigured to configured normal.
module usb_suspend_wake_state_control (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_usb_reset,
  input wire logic i_external_reset_pin_n,
  input wire logic i_eeprom_load_done,
  input wire logic i_usb_configured,
  input wire logic i_usb_deconfigured,
  input wire logic i_host_suspend,
  input wire logic i_host_resume,
  input wire logic i_sleep_sel_wr,
  input wire logic [pm_pkg::SEL_W-1:0] i_sleep_sel_wdata,
  input wire logic [pm_pkg::WS_W-1:0] i_wake_status_clr,
  input wire logic [pm_pkg::GPIO_W-1:0] i_pin_wake_clr,
  input wire logic i_lan_wake_enable,
  input wire logic i_energy_detect_enable,
  input wire logic i_frame_wake_src_en,
  input wire logic i_mac_lan_wake_evt,
  input wire logic i_mac_filter_pass,
  input wire logic i_phy_energy_evt,
  input wire logic i_phy_link_up,
  input wire logic i_link_up_wake_enable,
  input wire logic [pm_pkg::GPIO_W-1:0] i_gpio_pins,
  input wire logic [pm_pkg::GPIO_W-1:0] i_gpio_wake_en,
  input wire logic [pm_pkg::GPIO_W-1:0] i_gpio_pol,
  output logic o_ready,
  output logic [pm_pkg::SEL_W-1:0] o_sleep_sel,
  output pm_pkg::pm_state_type o_power_state,
  output logic o_configured,
  output logic o_suspended,
  output logic [pm_pkg::WS_W-1:0] o_wake_status,
  output logic [pm_pkg::GPIO_W-1:0] o_pin_wake_status,
  output logic o_link_up_wake_enable,
  output logic o_remote_wake,
  output logic o_hw_reinit,
  output logic o_clocks_enable,
  output logic o_phy_state_kept,
  output logic o_rx_drop_all
);
  import pm_pkg::*;

  wake_if wk ();

  pm_state_type state_r;
  pm_state_type state_nxt;
  logic from_conf_r;
  logic [SEL_W-1:0] sleep_sel_r;
  logic load_pending_r;
  logic [WS_W-1:0] wake_status_r;
  logic [GPIO_W-1:0] pin_wake_r;
  logic remote_wake_r;
  logic hw_reinit_r;
  logic pin_meta_r;
  logic pin_sync_r;
  logic pin_rst;
  logic hard_rst;
  logic is_normal;
  logic is_sleep;
  logic lan_evt;
  logic energy_evt;
  logic good_evt;
  logic pending_any;
  logic dev_wake;

  // External reset pin synchronised; active low on the pin
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_meta_r <= 1'b1;
      pin_sync_r <= 1'b1;
    end else begin
      pin_meta_r <= i_external_reset_pin_n;
      pin_sync_r <= pin_meta_r;
    end
  end

  assign pin_rst = ~pin_sync_r;
  assign hard_rst = i_usb_reset | pin_rst;
  assign is_normal = (state_r == ST_NORM_UNCONF) || (state_r == ST_NORM_CONF);
  assign is_sleep = ~is_normal;

  // Wake detector runs only while suspended; link-up only in s0 and s3
  assign wk.in_sleep = is_sleep;
  assign wk.link_allowed = (state_r == ST_SLEEP_S0) || (state_r == ST_SLEEP_S3);

  pin_wake_detect u_pin_wake (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_gpio_pins(i_gpio_pins),
    .i_gpio_wake_en(i_gpio_wake_en),
    .i_gpio_pol(i_gpio_pol),
    .i_phy_link_up(i_phy_link_up),
    .i_link_up_wake_enable(i_link_up_wake_enable),
    .wk(wk)
  );

  // Per-state wake gating of MAC and PHY events
  assign lan_evt = (state_r == ST_SLEEP_S0) && i_lan_wake_enable && i_mac_lan_wake_evt;
  assign energy_evt = (state_r == ST_SLEEP_S1) && i_energy_detect_enable && i_phy_energy_evt;
  // Lan wake enable is a don't-care here; any frame wake source blocks it
  assign good_evt = (state_r == ST_SLEEP_S3) && i_mac_filter_pass && !i_frame_wake_src_en;
  // Sticky status left uncleared before suspend wakes at once
  assign pending_any = (|wake_status_r) || (|pin_wake_r);
  assign dev_wake = lan_evt || energy_evt || good_evt || (|wk.gpio_evt) || pending_any;

  // State transition logic
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_NORM_UNCONF: begin
        if (i_host_suspend) begin
          state_nxt = ST_SLEEP_S2;
        end else if (i_usb_configured) begin
          state_nxt = ST_NORM_CONF;
        end
      end
      ST_NORM_CONF: begin
        if (i_usb_deconfigured) begin
          state_nxt = ST_NORM_UNCONF;
        end else if (i_host_suspend) begin
          case (sleep_sel_r)
            SEL_S0: state_nxt = ST_SLEEP_S0;
            SEL_S1: state_nxt = ST_SLEEP_S1;
            SEL_S2: state_nxt = ST_SLEEP_S2;
            default: state_nxt = ST_SLEEP_S3;
          endcase
        end
      end
      ST_SLEEP_S0, ST_SLEEP_S1, ST_SLEEP_S2, ST_SLEEP_S3: begin
        if (i_host_resume || dev_wake) begin
          state_nxt = from_conf_r ? ST_NORM_CONF : ST_NORM_UNCONF;
        end
      end
      default: state_nxt = ST_NORM_UNCONF;
    endcase
    if (hard_rst) begin
      state_nxt = ST_NORM_UNCONF;
    end
  end

  // State register
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r <= ST_NORM_UNCONF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Origin of the suspend, so wake returns to the right normal flavour
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      from_conf_r <= 1'b0;
    end else if (hard_rst) begin
      from_conf_r <= 1'b0;
    end else if (is_normal) begin
      from_conf_r <= (state_r == ST_NORM_CONF);
    end
  end

  // Suspend-select field; deconfiguration beats a same-cycle write
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sleep_sel_r <= SEL_RESET;
    end else if (hard_rst) begin
      sleep_sel_r <= SEL_RESET;
    end else if (state_r == ST_NORM_CONF && i_usb_deconfigured) begin
      sleep_sel_r <= SEL_S2;
    end else if (is_normal && i_sleep_sel_wr) begin
      sleep_sel_r <= i_sleep_sel_wdata;
    end
  end

  // Configuration load tracking after a reset
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      load_pending_r <= 1'b0;
    end else if (hard_rst) begin
      load_pending_r <= 1'b1;
    end else if (i_eeprom_load_done) begin
      load_pending_r <= 1'b0;
    end
  end

  // Wake status, set wins over a same-cycle clear
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wake_status_r <= WS_RESET;
    end else if (hard_rst) begin
      wake_status_r <= WS_RESET;
    end else begin
      wake_status_r[WS_LAN_BIT] <= (wake_status_r[WS_LAN_BIT] & ~i_wake_status_clr[WS_LAN_BIT])
                                   | lan_evt | good_evt;
      wake_status_r[WS_ENERGY_BIT] <= (wake_status_r[WS_ENERGY_BIT] & ~i_wake_status_clr[WS_ENERGY_BIT])
                                      | energy_evt;
    end
  end

  // Pin wake status, one bit per GPIO, set wins over clear
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_wake_r <= PIN_WS_RESET;
    end else if (hard_rst) begin
      pin_wake_r <= PIN_WS_RESET;
    end else begin
      pin_wake_r <= (pin_wake_r & ~i_pin_wake_clr) | wk.gpio_evt;
    end
  end

  // Remote wake only for device-side wakes; reinit only for hard resets
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      remote_wake_r <= 1'b0;
      hw_reinit_r <= 1'b0;
    end else begin
      remote_wake_r <= is_sleep && !hard_rst && !i_host_resume && dev_wake;
      hw_reinit_r <= hard_rst;
    end
  end

  // Outputs
  assign o_ready = is_normal && !load_pending_r;
  assign o_sleep_sel = sleep_sel_r;
  assign o_power_state = state_r;
  assign o_configured = (state_r == ST_NORM_CONF);
  assign o_suspended = is_sleep;
  assign o_wake_status = wake_status_r;
  assign o_pin_wake_status = pin_wake_r;
  assign o_link_up_wake_enable = i_link_up_wake_enable;
  assign o_remote_wake = remote_wake_r;
  assign o_hw_reinit = hw_reinit_r;
  // Clocks gated only in s0..s2; s3 trades power for quick frame wake
  assign o_clocks_enable = is_normal || (state_r == ST_SLEEP_S3);
  assign o_phy_state_kept = (state_r != ST_SLEEP_S2);
  assign o_rx_drop_all = (state_r == ST_SLEEP_S3) && i_frame_wake_src_en;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  property p_ready;
    (is_normal && !load_pending_r) |-> o_ready ##1 (!is_sleep || !o_ready);
  endproperty
  a_ready: assert property (p_ready) else $error("ready flag wrong for state");

  property p_sel_entry;
    (state_r == ST_NORM_CONF && i_host_suspend && !i_usb_deconfigured && !hard_rst && sleep_sel_r == SEL_S0)
      |=> (state_r == ST_SLEEP_S0);
  endproperty
  a_sel_entry: assert property (p_sel_entry) else $error("selected suspend not entered");

  property p_unconf_s2;
    (state_r == ST_NORM_UNCONF && i_host_suspend && !hard_rst) |=> (state_r == ST_SLEEP_S2) && !from_conf_r;
  endproperty
  a_unconf_s2: assert property (p_unconf_s2) else $error("unconfigured suspend not s2");

  property p_deconf;
    (state_r == ST_NORM_CONF && i_usb_deconfigured && !hard_rst)
      |=> (sleep_sel_r == SEL_S2) && (state_r == ST_NORM_UNCONF);
  endproperty
  a_deconf: assert property (p_deconf) else $error("deconfigure did not revert");

  property p_hard_reset;
    (is_sleep && hard_rst) |=> (state_r == ST_NORM_UNCONF) && o_hw_reinit;
  endproperty
  a_hard_reset: assert property (p_hard_reset) else $error("reset from suspend failed");

  property p_resume_conf;
    (is_sleep && from_conf_r && i_host_resume && !hard_rst) |=> (state_r == ST_NORM_CONF) ##1 !o_hw_reinit;
  endproperty
  a_resume_conf: assert property (p_resume_conf) else $error("resume lost configured state");

  property p_pin_status;
    (|wk.gpio_evt && !hard_rst) |=> ((pin_wake_r & $past(wk.gpio_evt)) == $past(wk.gpio_evt));
  endproperty
  a_pin_status: assert property (p_pin_status) else $error("pin wake status not set");

  property p_pending;
    (is_sleep && pending_any && !hard_rst) |=> is_normal;
  endproperty
  a_pending: assert property (p_pending) else $error("pending wake did not wake");

  property p_s3_drop;
    (state_r == ST_SLEEP_S3) |-> o_clocks_enable && (o_rx_drop_all == i_frame_wake_src_en);
  endproperty
  a_s3_drop: assert property (p_s3_drop) else $error("s3 clock or drop wrong");

  property p_good_frame;
    (state_r == ST_SLEEP_S3 && i_mac_filter_pass && !i_frame_wake_src_en && !hard_rst)
      |=> wake_status_r[WS_LAN_BIT] && is_normal;
  endproperty
  a_good_frame: assert property (p_good_frame) else $error("good frame wake missed");

  property p_config;
    (state_r == ST_NORM_UNCONF && i_usb_configured && !i_host_suspend && !hard_rst) |=> o_configured;
  endproperty
  a_config: assert property (p_config) else $error("configuration not taken");
endmodule : usb_suspend_wake_state_control

/* rtl/wake_if.sv */
/*
  Carrier between the state controller and the pin wake detector.
  Assumes both ends sit on the same core clock.
*/
interface wake_if;
  import pm_pkg::*;
  logic in_sleep;
  logic link_allowed;
  logic [GPIO_W-1:0] gpio_evt;

  modport det (input in_sleep, input link_allowed, output gpio_evt);
  modport ctl (output in_sleep, output link_allowed, input gpio_evt);
endinterface : wake_if

/* tb/host_model.sv */
/*
  Host controller and driver model: issues USB requests and register writes
  as one-cycle pulses. Assumes the bench calls its tasks; all changes land on
  falling edges of the shared core clock.
*/
module host_model (
  input wire logic i_ref_clk,
  input wire logic i_phy_state_kept,
  output logic [4:0] o_req,
  output logic o_sel_wr,
  output logic [1:0] o_sel_data,
  output logic [1:0] o_ws_clr,
  output logic [10:0] o_pin_clr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic phy_redo_r = 1'b0;

  // Idle at time zero; request bits: reset, configured, deconfigured, suspend, resume
  initial begin
    o_req = 5'h00;
    o_sel_wr = 1'b0;
    o_sel_data = 2'h0;
    o_ws_clr = 2'h0;
    o_pin_clr = 11'h000;
  end

  // PHY lost in deepest sleep, so the driver sets it up again; done by the next suspend
  always @(posedge i_ref_clk) begin
    if (i_phy_state_kept === 1'b0) begin
      phy_redo_r <= 1'b1;
    end else if (o_req[3]) begin
      phy_redo_r <= 1'b0;
    end
  end

  // One-cycle request pulse
  task automatic pulse(input int k);
    @(negedge i_ref_clk);
    o_req = 5'h01 << k;
    @(negedge i_ref_clk);
    o_req = 5'h00;
  endtask : pulse

  // Released data shows the inverse, not the last value
  task automatic write_sel(input logic [1:0] s);
    @(negedge i_ref_clk);
    o_sel_wr = 1'b1;
    o_sel_data = s;
    @(negedge i_ref_clk);
    o_sel_wr = 1'b0;
    o_sel_data = ~s;
  endtask : write_sel

  // Select first, then suspend signalling
  task automatic sleep(input logic [1:0] s);
    write_sel(s);
    pulse(3);
  endtask : sleep

  // Pending wakes cleared before any suspend
  task automatic clear();
    @(negedge i_ref_clk);
    o_ws_clr = 2'h3;
    o_pin_clr = 11'h7ff;
    @(negedge i_ref_clk);
    o_ws_clr = 2'h0;
    o_pin_clr = 11'h000;
  endtask : clear
endmodule : host_model

/* tb/usb_suspend_wake_state_control_tb.sv */
/*
  Self-checking bench for the suspend/wake controller: a table of wake cases
  per suspend state, then reset, deconfigure and pending-wake cases.
  Assumes pm_pkg and the design files are compiled first.
*/
module usb_suspend_wake_state_control_tb;
  import pm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [1:0] sel; logic [2:0] ev; logic wake; logic [1:0] ws; logic [10:0] pws;
    logic en;} row_type;
  logic clk, rst, pin_rst_n, eeprom_done, lan_en, ed_en, fsrc_en, lan_evt, filt, energy, link, link_en;
  logic [10:0] gpio, gwen, gpol, pin_clr, pws;
  logic [4:0] req;
  logic sel_wr, ready, configd, susp, lwe, rwake, reinit, clk_en, phy_kept, drop;
  logic [1:0] sel_d, ws_clr, sel, ws;
  pm_state_type st;
  int fails, cmp_count, reinit_base;
  int reinit_cnt = 0;
  pm_state_type sleep_st [4] = '{ST_SLEEP_S0, ST_SLEEP_S1, ST_SLEEP_S2, ST_SLEEP_S3};
  // Events: 0 lan, 1 energy, 2 good frame, 3 link up, 4 pin 3; en drives the matching enables
  row_type rows [14] = '{{2'h0, 3'h0, 1'b1, 2'h1, 11'h000, 1'b1}, {2'h1, 3'h0, 1'b0, 2'h0, 11'h000, 1'b1},
    {2'h1, 3'h1, 1'b1, 2'h2, 11'h000, 1'b1}, {2'h2, 3'h1, 1'b0, 2'h0, 11'h000, 1'b1},
    {2'h3, 3'h2, 1'b1, 2'h1, 11'h000, 1'b1}, {2'h0, 3'h2, 1'b0, 2'h0, 11'h000, 1'b1},
    {2'h3, 3'h3, 1'b1, 2'h0, 11'h080, 1'b1}, {2'h1, 3'h3, 1'b0, 2'h0, 11'h000, 1'b1},
    {2'h2, 3'h4, 1'b1, 2'h0, 11'h008, 1'b1}, {2'h0, 3'h3, 1'b1, 2'h0, 11'h080, 1'b1},
    {2'h0, 3'h0, 1'b0, 2'h0, 11'h000, 1'b0}, {2'h1, 3'h1, 1'b0, 2'h0, 11'h000, 1'b0},
    {2'h3, 3'h3, 1'b0, 2'h0, 11'h000, 1'b0}, {2'h2, 3'h4, 1'b0, 2'h0, 11'h000, 1'b0}};

  usb_suspend_wake_state_control i_usb_suspend_wake_state_control (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_usb_reset(req[0]), .i_external_reset_pin_n(pin_rst_n),
    .i_eeprom_load_done(eeprom_done), .i_usb_configured(req[1]), .i_usb_deconfigured(req[2]),
    .i_host_suspend(req[3]), .i_host_resume(req[4]), .i_sleep_sel_wr(sel_wr), .i_sleep_sel_wdata(sel_d),
    .i_wake_status_clr(ws_clr), .i_pin_wake_clr(pin_clr), .i_lan_wake_enable(lan_en),
    .i_energy_detect_enable(ed_en), .i_frame_wake_src_en(fsrc_en), .i_mac_lan_wake_evt(lan_evt),
    .i_mac_filter_pass(filt), .i_phy_energy_evt(energy), .i_phy_link_up(link), .i_link_up_wake_enable(link_en),
    .i_gpio_pins(gpio), .i_gpio_wake_en(gwen), .i_gpio_pol(gpol), .o_ready(ready), .o_sleep_sel(sel),
    .o_power_state(st), .o_configured(configd), .o_suspended(susp), .o_wake_status(ws),
    .o_pin_wake_status(pws), .o_link_up_wake_enable(lwe), .o_remote_wake(rwake), .o_hw_reinit(reinit),
    .o_clocks_enable(clk_en), .o_phy_state_kept(phy_kept), .o_rx_drop_all(drop));

  host_model i_host_model (.i_ref_clk(clk), .i_phy_state_kept(phy_kept), .o_req(req), .o_sel_wr(sel_wr),
    .o_sel_data(sel_d), .o_ws_clr(ws_clr), .o_pin_clr(pin_clr));

  // 100 MHz core clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Count reinit cycles so a one-cycle pulse is never missed between samples
  always @(posedge clk) begin
    if (reinit === 1'b1) reinit_cnt++;
  end

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // Pulses dropped after one cycle; link and pin stay up as levels
  task automatic fire(input logic [2:0] k);
    @(negedge clk);
    case (k)
      3'h0: lan_evt = 1'b1;
      3'h1: energy = 1'b1;
      3'h2: filt = 1'b1;
      3'h3: link = 1'b1;
      default: gpio[3] = 1'b1;
    endcase
    @(negedge clk);
    {lan_evt, energy, filt} = 3'h0;
  endtask : fire

  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #200us;
    fails++;
    test_done();
  end

  initial begin
    {rst, eeprom_done, fsrc_en, lan_evt, filt, energy, link} = 7'h40;
    {pin_rst_n, lan_en, ed_en, link_en} = 4'hf;
    gpio = 11'h000;
    gwen = 11'h088;
    gpol = 11'h7ff;
    fails = 0;
    cmp_count = 0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("reset state", 16'(ST_NORM_UNCONF), 16'(st));
    chk("reset ready", 16'h1, 16'(ready));
    chk("reset sel", 16'(SEL_RESET), 16'(sel));
    chk("reset status", 16'h0, {3'h0, ws, pws});
    $display("test reset done");
    // Permitted and refused wake sources per suspend state
    foreach (rows[i]) begin
      {lan_en, ed_en, link_en} = {3{rows[i].en}};
      gwen[3] = rows[i].en;
      i_host_model.pulse(1);
      chk("configured", 16'h1, 16'(configd));
      i_host_model.sleep(rows[i].sel);
      chk("sleep state", 16'(sleep_st[rows[i].sel]), 16'(st));
      chk("sleep ready", 16'h0, 16'(ready));
      chk("suspended", 16'h1, 16'(susp));
      chk("sleep clocks", 16'(rows[i].sel == SEL_S3), 16'(clk_en));
      chk("link mode", 16'(rows[i].en), 16'(lwe));
      fire(rows[i].ev);
      if (rows[i].ev < 3'h3) chk("remote wake", 16'(rows[i].wake), 16'(rwake));
      repeat (6) @(negedge clk);
      chk("wake state", 16'(rows[i].wake ? ST_NORM_CONF : sleep_st[rows[i].sel]), 16'(st));
      chk("wake status", 16'(rows[i].ws), 16'(ws));
      chk("pin status", 16'(rows[i].pws), 16'(pws));
      if (!rows[i].wake) i_host_model.pulse(4);
      chk("back configured", 16'(ST_NORM_CONF), 16'(st));
      link = 1'b0;
      gpio[3] = 1'b0;
      i_host_model.clear();
    end
    $display("test table done");
    {lan_en, ed_en, link_en} = 3'h7;
    gwen[3] = 1'b1;
    // Status left set wakes the device straight back
    i_host_model.sleep(2'h0);
    fire(3'h0);
    repeat (3) @(negedge clk);
    i_host_model.sleep(2'h0);
    @(negedge clk);
    chk("rewake pulse", 16'h1, 16'(rwake));
    repeat (3) @(negedge clk);
    chk("rewake", 16'(ST_NORM_CONF), 16'(st));
    i_host_model.clear();
    $display("test pending done");
    // Deconfigure, then suspend from unconfigured
    i_host_model.write_sel(2'h3);
    i_host_model.pulse(2);
    chk("deconf state", 16'(ST_NORM_UNCONF), 16'(st));
    chk("deconf sel", 16'(SEL_S2), 16'(sel));
    i_host_model.sleep(2'h0);
    chk("unconf sleep", 16'(ST_SLEEP_S2), 16'(st));
    chk("phy kept", 16'h0, 16'(phy_kept));
    i_host_model.write_sel(2'h1);
    chk("sel frozen", 16'(SEL_S0), 16'(sel));
    chk("phy redo", 16'h1, 16'(i_host_model.phy_redo_r));
    reinit_base = reinit_cnt;
    i_host_model.pulse(4);
    repeat (2) @(negedge clk);
    chk("unconf back", 16'(ST_NORM_UNCONF), 16'(st));
    chk("ready back", 16'h1, 16'(ready));
    chk("context kept", 16'h0, 16'(reinit_cnt - reinit_base));
    $display("test deconfigure done");
    // Deepest-power-saving exceptions of sleep_s3, then USB reset
    i_host_model.pulse(1);
    i_host_model.sleep(2'h3);
    chk("s3 clocks", 16'h1, 16'(clk_en));
    fsrc_en = 1'b1;
    fire(3'h2);
    chk("drop all", 16'h1, 16'(drop));
    repeat (4) @(negedge clk);
    chk("no frame wake", 16'(ST_SLEEP_S3), 16'(st));
    chk("link enable", 16'h1, 16'(lwe));
    reinit_base = reinit_cnt;
    i_host_model.pulse(0);
    @(negedge clk);
    chk("usb reset state", 16'(ST_NORM_UNCONF), 16'(st));
    chk("usb reset sel", 16'(SEL_S2), 16'(sel));
    chk("reinit seen", 16'h1, 16'(reinit_cnt - reinit_base));
    chk("load pending", 16'h0, 16'(ready));
    eeprom_done = 1'b1;
    @(negedge clk);
    eeprom_done = 1'b0;
    fsrc_en = 1'b0;
    chk("loaded", 16'h1, 16'(ready));
    $display("test usb reset done");
    // Pin reset reaches sleep_s1 through its synchroniser
    i_host_model.pulse(1);
    i_host_model.sleep(2'h1);
    pin_rst_n = 1'b0;
    repeat (2) @(negedge clk);
    pin_rst_n = 1'b1;
    repeat (5) @(negedge clk);
    chk("pin reset state", 16'(ST_NORM_UNCONF), 16'(st));
    $display("test pin reset done");
    // Active-low pin: idle high while asleep, wake on the drop
    gpol[3] = 1'b0;
    gpio[3] = 1'b1;
    repeat (4) @(negedge clk);
    i_host_model.sleep(2'h1);
    chk("pol sleep", 16'(ST_SLEEP_S2), 16'(st));
    gpio[3] = 1'b0;
    repeat (5) @(negedge clk);
    chk("pol wake", 16'(ST_NORM_UNCONF), 16'(st));
    chk("pol status", 16'h008, 16'(pws));
    $display("test polarity done");
    test_done();
  end
endmodule : usb_suspend_wake_state_control_tb
